//--- common/spi_port_pkg.sv
// Shared constants, register map and carrier types for the serial port block
package spi_port_pkg;

  // ****************************************************************
  // Register indices on the local register port
  // ****************************************************************
  localparam logic [2:0] ADDR_CTRL1   = 3'h0;   // Serial control 1
  localparam logic [2:0] ADDR_CTRL2   = 3'h1;   // Serial control 2
  localparam logic [2:0] ADDR_DIVIDER = 3'h2;   // Clock rate select
  localparam logic [2:0] ADDR_FLAGS   = 3'h3;   // Status flags
  localparam logic [2:0] ADDR_DATA    = 3'h4;   // Shift data
  localparam logic [2:0] ADDR_PINS    = 3'h5;   // Port pin data
  localparam logic [2:0] ADDR_DIR     = 3'h6;   // Port direction
  localparam logic [2:0] ADDR_PULLDRV = 3'h7;   // Pull-up and drive groups

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL1_RST    = 8'h00;  // Slave, disabled
  localparam logic [7:0] CTRL2_RST    = 8'h00;  // Normal pins
  localparam logic [2:0] DIVIDER_RST  = 3'h0;   // Divide by two
  localparam logic [7:0] DIR_RST      = 8'h00;  // All pins input
  localparam logic [7:0] LATCH_RST    = 8'h00;  // Port latch
  localparam logic [7:0] PULLDRV_RST  = 8'h00;  // No pulls, full drive

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FLAG_DONE_POS   = 7;           // Transfer complete
  localparam int FLAG_COLL_POS   = 6;           // Write collision
  localparam int FLAG_FAULT_POS  = 4;           // Mode fault
  localparam int PD_PU_UPPER_POS = 6;           // Pull-up pins 7..4
  localparam int PD_PU_MID_POS   = 5;           // Pull-up pins 3..2
  localparam int PD_PU_LOW_POS   = 4;           // Pull-up pins 1..0
  localparam int PD_RD_UPPER_POS = 2;           // Reduced drive 7..4
  localparam int PD_RD_MID_POS   = 1;           // Reduced drive 3..2
  localparam int PD_RD_LOW_POS   = 0;           // Reduced drive 1..0
  localparam int PIN_RXD  = 0;                  // Async receive pin
  localparam int PIN_TXD  = 1;                  // Async transmit pin
  localparam int PIN_MISO = 4;                  // Slave data out
  localparam int PIN_MOSI = 5;                  // Master data out
  localparam int PIN_SCK  = 6;                  // Serial clock
  localparam int PIN_SEL  = 7;                  // Slave select

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [3:0] LAST_EDGE = 4'hF;      // Sixteenth clock edge

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic serial_irq_enable;
    logic serial_system_enable;
    logic wired_or_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic select_output_enable;
    logic lsb_first;
  } ctrl1_t;

  typedef struct packed {
    logic [3:0] spare;
    logic       port_pullup_enable;
    logic       port_reduced_drive;
    logic       spare0;
    logic       bidir_pin_control;
  } ctrl2_t;

  typedef struct packed {
    logic [2:0] addr;   // Register index
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } reg_req_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } xfer_state_t;

endpackage

//--- core/spi_port.sv
// Serial peripheral port with shared eight-pin general-purpose port
//
// Function
// (R1) Wired-or makes upper and serial outputs open-drain
// (R2) Master-select bit chooses slave or master
// (R3) Idle master clock follows polarity bit
// (R4) Bit order selectable, register keeps MSB
// (R5) Select output only master, enable and dir7
// (R6) Bidirectional mode uses one data pin
// (R7) Slave output needs dir4, select low, slave
// (R8) Master data needs dir5, clock dir6
// (R9) Port pull-up only on input pins
// (R10) Clock divisor two to 256, reset two
// (R11) Complete flag set, cleared read-then-data
// (R12) Busy write discarded, collision flag set
// (R13) Master select low sets fault unless dir7 or select output enable
// (R14) Fault clears by read then control write
// (R15) Read buffered byte, write loads shifter
// (R16) Reset clears all direction bits
// (R17) Port read gives pin or driver level
// (R18) Port latch drives only general outputs
// (R19) Async two-wire forces pin0 in, pin1 out
// (R20) Enabled port forces serial inputs in
// (R21) Pin 7 role depends on master mode
// (R22) Three pull-up and drive groups
// (R23) Phase bit picks sampling edge
// (R24) Interrupt on complete or fault flag
// (R25) Select output low during each transfer
// (R26) Master write while idle starts transfer
`timescale 1ns/1ns
module spi_port
  import spi_port_pkg::*;
(
  input  wire logic     core_clk_i,     // Bus clock
  input  wire logic     resetn_i,       // Synchronous reset, low
  input  wire reg_req_t reg_req_i,      // Register request
  output logic [7:0]    reg_rdata_o,    // Read data, cycle after read
  input  wire logic [7:0] pin_i,        // Pin levels
  output logic [7:0]    pin_o,          // Pin drive values
  output logic [7:0]    pin_oe_o,       // Pin drive enables
  output logic [7:0]    pullup_o,       // Pull-up enables
  output logic [7:0]    reduced_drive_o,// Reduced drive enables
  input  wire logic     async_rx_en_i,  // Async receiver two-wire
  input  wire logic     async_tx_en_i,  // Async transmitter two-wire
  input  wire logic     async_txd_i,    // Async transmit data
  output logic          irq_o           // Interrupt request
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  ctrl1_t      ctrl1_r;          // Control 1
  ctrl2_t      ctrl2_r;          // Control 2
  logic [2:0]  rate_r;           // Clock rate select
  logic [7:0]  dir_r;            // Port direction
  logic [7:0]  latch_r;          // Port output latch
  logic [7:0]  pulldrv_r;        // Pull and drive groups
  logic        done_r;           // Transfer complete flag
  logic        coll_r;           // Write collision flag
  logic        fault_r;          // Mode fault flag
  logic        done_arm_r;       // Status read saw complete
  logic        coll_arm_r;       // Status read saw collision
  logic        fault_arm_r;      // Status read saw fault
  logic [7:0]  shift_r;          // Shifter
  logic [7:0]  rxbuf_r;          // Received byte buffer
  logic        out_bit_r;        // Bit on the data output
  xfer_state_t state_r;          // Transfer state
  logic [3:0]  edge_cnt_r;       // Clock edges in transfer
  logic [6:0]  div_cnt_r;        // Divider counter
  logic        sck_r;            // Master clock level
  logic        sck_prev_r;       // Previous slave clock level
  logic [7:0]  rdata_r;          // Read data
  logic [7:0]  pin_o_r;          // Pin values
  logic [7:0]  pin_oe_r;         // Pin enables
  logic [7:0]  pullup_r;         // Pull-ups
  logic [7:0]  rdrive_r;         // Reduced drive
  logic        irq_r;            // Interrupt

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire wr_ctrl1  = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL1);
  wire wr_ctrl2  = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL2);
  wire wr_rate   = reg_req_i.wr && (reg_req_i.addr == ADDR_DIVIDER);
  wire wr_data   = reg_req_i.wr && (reg_req_i.addr == ADDR_DATA);
  wire wr_pins   = reg_req_i.wr && (reg_req_i.addr == ADDR_PINS);
  wire wr_dir    = reg_req_i.wr && (reg_req_i.addr == ADDR_DIR);
  wire wr_pd     = reg_req_i.wr && (reg_req_i.addr == ADDR_PULLDRV);
  wire rd_flags  = reg_req_i.rd && (reg_req_i.addr == ADDR_FLAGS);
  wire rd_data   = reg_req_i.rd && (reg_req_i.addr == ADDR_DATA);
  wire data_acc  = wr_data || rd_data;   // Any data register access

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire enabled   = ctrl1_r.serial_system_enable;
  wire master    = enabled && ctrl1_r.master_select;          // (R2)
  wire slave     = enabled && !ctrl1_r.master_select;         // (R2)
  wire bidir     = ctrl2_r.bidir_pin_control;
  wire busy      = (state_r == ST_BUSY);
  wire sel_in    = pin_i[PIN_SEL];
  wire sel_out   = master && dir_r[PIN_SEL] && ctrl1_r.select_output_enable; // (R5)
  // Data input pin: bidirectional mode reuses the output pin
  wire data_in   = master ? (bidir ? pin_i[PIN_MOSI] : pin_i[PIN_MISO])
                          : (bidir ? pin_i[PIN_MISO] : pin_i[PIN_MOSI]); // (R6)
  // Current outgoing bit of the shifter
  wire cur_out   = ctrl1_r.lsb_first ? shift_r[0] : shift_r[7];  // (R4)
  // Shifter after taking one bit in
  wire [7:0] shifted = ctrl1_r.lsb_first ? {data_in, shift_r[7:1]}
                                         : {shift_r[6:0], data_in}; // (R4)
  // Mode fault: master with select input low and pin 7 as input
  wire fault_set = master && !dir_r[PIN_SEL] && !sel_in;      // (R13)

  // ****************************************************************
  // Clock divider, half period is 2^rate cycles
  // ****************************************************************
  wire [6:0] half_m1 = 7'((8'h01 << rate_r) - 8'h01);          // (R10)
  wire       tick    = master && busy && (div_cnt_r == half_m1); // (R10)

  // ****************************************************************
  // Clock edge events, master or slave
  // ****************************************************************
  wire slave_act  = slave && !sel_in;
  wire slave_edge = slave_act && (pin_i[PIN_SCK] != sck_prev_r);
  wire ev         = tick || slave_edge;
  // Leading edge leaves the idle level
  wire lead       = master ? (sck_r == ctrl1_r.clock_polarity)
                           : (pin_i[PIN_SCK] != ctrl1_r.clock_polarity);
  wire sample     = ev && (lead != ctrl1_r.clock_phase);      // (R23)
  wire launch     = ev && (lead == ctrl1_r.clock_phase);      // (R23)
  wire last_edge  = ev && (edge_cnt_r == LAST_EDGE);
  wire complete   = last_edge && (busy || slave_act);         // (R11)
  wire start      = wr_data && !busy && master;               // (R26)
  wire collide    = wr_data && busy;                          // (R12)
  wire abort      = busy && ((master && fault_set) || (slave && sel_in) || !enabled);

  // ****************************************************************
  // Control and port registers
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      ctrl1_r   <= ctrl1_t'(CTRL1_RST);
      ctrl2_r   <= ctrl2_t'(CTRL2_RST);
      rate_r    <= DIVIDER_RST;                               // (R10)
      dir_r     <= DIR_RST;                                   // (R16)
      latch_r   <= LATCH_RST;
      pulldrv_r <= PULLDRV_RST;
    end
    else
    begin
      if (fault_set && !ctrl1_r.select_output_enable)
      begin
        // Fault drops the enable and master bits
        ctrl1_r.serial_system_enable <= 1'b0;
        ctrl1_r.master_select        <= 1'b0;
      end
      else if (wr_ctrl1)
        ctrl1_r <= ctrl1_t'(reg_req_i.wdata);
      if (wr_ctrl2)
        ctrl2_r <= ctrl2_t'(reg_req_i.wdata);
      if (wr_rate)
        rate_r <= reg_req_i.wdata[2:0];
      if (wr_dir)
        dir_r <= reg_req_i.wdata;
      if (wr_pins)
        latch_r <= reg_req_i.wdata;                           // (R18)
      if (wr_pd)
        pulldrv_r <= reg_req_i.wdata;                         // (R22)
    end
  end

  // ****************************************************************
  // Status flags; a set in the clearing cycle wins
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      done_r      <= 1'b0;
      coll_r      <= 1'b0;
      fault_r     <= 1'b0;
      done_arm_r  <= 1'b0;
      coll_arm_r  <= 1'b0;
      fault_arm_r <= 1'b0;
    end
    else
    begin
      // Complete flag
      done_r <= complete || (done_r && !(done_arm_r && data_acc));    // (R11)
      // Collision flag
      coll_r <= collide || (coll_r && !(coll_arm_r && data_acc));     // (R12)
      // Fault flag
      fault_r <= (fault_set && !ctrl1_r.select_output_enable)
                 || (fault_r && !(fault_arm_r && wr_ctrl1));          // (R14)
      // Arm on a status read that sees the flag
      done_arm_r  <= rd_flags ? done_r  : (data_acc ? 1'b0 : done_arm_r);
      coll_arm_r  <= rd_flags ? coll_r  : (data_acc ? 1'b0 : coll_arm_r);
      fault_arm_r <= rd_flags ? fault_r : (wr_ctrl1 ? 1'b0 : fault_arm_r);
    end
  end

  // ****************************************************************
  // Transfer engine
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      state_r    <= ST_IDLE;
      edge_cnt_r <= 4'h0;
      div_cnt_r  <= 7'h00;
      sck_r      <= 1'b0;
      sck_prev_r <= 1'b0;
      shift_r    <= 8'h00;
      rxbuf_r    <= 8'h00;
      out_bit_r  <= 1'b0;
    end
    else
    begin
      sck_prev_r <= slave_act ? pin_i[PIN_SCK] : ctrl1_r.clock_polarity;
      // Divider runs during any transfer, ticks only in master mode
      div_cnt_r <= (tick || !busy) ? 7'h00 : 7'(div_cnt_r + 7'h01);   // (R10)
      // Master clock toggles per tick, rests at polarity
      if (!(busy && master))
        sck_r <= ctrl1_r.clock_polarity;                      // (R3)
      else if (tick)
        sck_r <= !sck_r;
      // Edge counter
      if (abort || !(busy || slave_act))
        edge_cnt_r <= 4'h0;
      else if (ev)
        edge_cnt_r <= 4'(edge_cnt_r + 4'h1);
      // Transfer state
      if (abort || complete)
        state_r <= ST_IDLE;
      else if (start || slave_edge)
        state_r <= ST_BUSY;                                   // (R26)
      // Shifter: write loads directly, sample shifts in
      if (wr_data && !busy)
        shift_r <= reg_req_i.wdata;                           // (R15)
      else if (sample)
        shift_r <= shifted;                                   // (R15)
      // Received byte goes to the read buffer
      if (complete)
        rxbuf_r <= sample ? shifted : shift_r;                // (R15)
      // Output bit follows shifter while idle, moves on launch
      if (!(busy || slave_act) || launch)
        out_bit_r <= (wr_data && !busy) ? (ctrl1_r.lsb_first ? reg_req_i.wdata[0]
                                                             : reg_req_i.wdata[7])
                                        : cur_out;            // (R4)
    end
  end

  // ****************************************************************
  // Pin assignment, one wire set per pin
  // ****************************************************************
  logic [7:0] drv_oe;   // Drive enable before open-drain
  logic [7:0] drv_val;  // Drive value before open-drain
  logic [7:0] fin_oe;   // Final enable
  logic [7:0] fin_val;  // Final value
  logic [7:0] grp_pu;   // Pull-up group per pin
  logic [7:0] grp_rd;   // Drive group per pin

  always_comb
  begin
    // General-purpose defaults
    drv_oe  = dir_r;                                          // (R18)
    drv_val = latch_r;                                        // (R18)
    // Async two-wire overrides
    if (async_rx_en_i)
      drv_oe[PIN_RXD] = 1'b0;                                 // (R19)
    if (async_tx_en_i)
    begin
      drv_oe[PIN_TXD]  = 1'b1;                                // (R19)
      drv_val[PIN_TXD] = async_txd_i;                         // (R19)
    end
    if (slave)
    begin
      // Slave data out on MISO; clock, select and, unless bidirectional, MOSI inputs
      drv_oe[PIN_MISO]  = dir_r[PIN_MISO] && !sel_in;         // (R7)
      drv_val[PIN_MISO] = out_bit_r;
      if (!bidir)
        drv_oe[PIN_MOSI] = 1'b0;                              // (R20)
      drv_oe[PIN_SCK] = 1'b0;                                 // (R20)
      drv_oe[PIN_SEL] = 1'b0;                                 // (R21)
    end
    else if (master)
    begin
      if (!bidir)
        drv_oe[PIN_MISO] = 1'b0;                              // (R20)
      drv_oe[PIN_MOSI]  = dir_r[PIN_MOSI];                    // (R8)
      drv_val[PIN_MOSI] = out_bit_r;                          // (R6)
      drv_oe[PIN_SCK]   = dir_r[PIN_SCK];                     // (R8)
      drv_val[PIN_SCK]  = sck_r;                              // (R3)
      if (sel_out)
        drv_val[PIN_SEL] = !busy;                             // (R25)
      else if (!dir_r[PIN_SEL])
        drv_oe[PIN_SEL] = 1'b0;                               // (R21)
    end
    // Open-drain on serial and upper pins
    fin_oe  = drv_oe;
    fin_val = drv_val;
    if (ctrl1_r.wired_or_enable)
    begin
      fin_oe[7:4]  = drv_oe[7:4] & ~drv_val[7:4];             // (R1)
      fin_val[7:4] = 4'h0;                                    // (R1)
    end
    // Group enables
    grp_pu = {{4{pulldrv_r[PD_PU_UPPER_POS]}}, {2{pulldrv_r[PD_PU_MID_POS]}},
              {2{pulldrv_r[PD_PU_LOW_POS]}}};                 // (R22)
    grp_rd = {{4{pulldrv_r[PD_RD_UPPER_POS]}}, {2{pulldrv_r[PD_RD_MID_POS]}},
              {2{pulldrv_r[PD_RD_LOW_POS]}}};                 // (R22)
  end

  // Read of port data: pin for inputs, driver value for outputs
  wire [7:0] port_read = (drv_oe & drv_val) | (~drv_oe & pin_i);  // (R17)
  // Flag byte
  wire [7:0] flags_read = (8'(done_r) << FLAG_DONE_POS) | (8'(coll_r) << FLAG_COLL_POS)
                          | (8'(fault_r) << FLAG_FAULT_POS);
  // Control 1 reads the enable as zero under fault
  wire [7:0] ctrl1_read = fault_r ? (8'(ctrl1_r) & 8'hBF) : 8'(ctrl1_r);

  // Read mux
  logic [7:0] rsel;
  always_comb
  begin
    unique case (reg_req_i.addr)
      ADDR_CTRL1:   rsel = ctrl1_read;
      ADDR_CTRL2:   rsel = 8'(ctrl2_r);
      ADDR_DIVIDER: rsel = {5'h00, rate_r};
      ADDR_FLAGS:   rsel = flags_read;
      ADDR_DATA:    rsel = rxbuf_r;                           // (R15)
      ADDR_PINS:    rsel = port_read;                         // (R17)
      ADDR_DIR:     rsel = dir_r;
      ADDR_PULLDRV: rsel = pulldrv_r;
    endcase
  end

  // ****************************************************************
  // Output flops
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_r  <= 8'h00;
      pin_o_r  <= 8'h00;
      pin_oe_r <= 8'h00;                                      // (R16)
      pullup_r <= 8'h00;
      rdrive_r <= 8'h00;
      irq_r    <= 1'b0;
    end
    else
    begin
      rdata_r  <= reg_req_i.rd ? rsel : 8'h00;
      pin_o_r  <= fin_val;
      pin_oe_r <= fin_oe;
      // Pull-ups only on pins not driving
      pullup_r <= ~drv_oe & (grp_pu | {8{ctrl2_r.port_pullup_enable}}); // (R9)
      rdrive_r <= grp_rd | {8{ctrl2_r.port_reduced_drive}};
      irq_r    <= ctrl1_r.serial_irq_enable && (done_r || fault_r);     // (R24)
    end
  end

  assign reg_rdata_o     = rdata_r;
  assign pin_o           = pin_o_r;
  assign pin_oe_o        = pin_oe_r;
  assign pullup_o        = pullup_r;
  assign reduced_drive_o = rdrive_r;
  assign irq_o           = irq_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_done_sets: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R11)
    complete |=> done_r) else $error("complete flag not set");
  a_coll_sets: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R12)
    collide |=> coll_r && $stable(rxbuf_r)) else $error("collision not flagged");
  a_fault_inhibit: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R13)
    $rose(fault_r) |-> $past(!dir_r[PIN_SEL] && !sel_in)) else $error("bad fault");
  a_dir_reset: assert property (@(posedge core_clk_i) // (R16)
    !resetn_i |=> dir_r == 8'h00 && pin_oe_o == 8'h00) else $error("dir not cleared");
  a_sck_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R3)
    (master && !busy) [*2] |-> sck_r == $past(ctrl1_r.clock_polarity)) else $error("sck idle");
  a_slave_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R7)
    $past(slave) && pin_oe_o[PIN_MISO] |-> $past(dir_r[PIN_MISO] && !sel_in))
    else $error("slave out gate");
  a_open_drain: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R1)
    $past(ctrl1_r.wired_or_enable) |-> (pin_o_r[7:4] == 4'h0)) else $error("not open drain");
  a_irq_follows: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R24)
    irq_o == $past(ctrl1_r.serial_irq_enable && (done_r || fault_r))) else $error("irq");
  a_start_busy: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // (R26)
    start && !abort |=> busy) else $error("no start");

endmodule // spi_port

//--- verification/spi_slave_model.sv
// Behavioural serial slave, clock mode 0, most significant bit first
`timescale 1ns/1ns
module spi_slave_model
(
  input  wire logic       sck_i,   // Serial clock from master
  input  wire logic       mosi_i,  // Master data
  input  wire logic       sel_n_i, // Select, active low
  input  wire logic [7:0] tx_i,    // Byte to return
  output logic            miso_o,  // Slave data
  output logic [7:0]      rx_o     // Byte received
);
  logic [7:0] sh_r = 8'h00;        // Outgoing shifter
  // Load on select, sample on rising, launch on falling
  always @(negedge sel_n_i) sh_r = tx_i;
  always @(posedge sck_i) if (!sel_n_i) rx_o = {rx_o[6:0], mosi_i};
  always @(negedge sck_i) if (!sel_n_i) sh_r = {sh_r[6:0], 1'b0};
  // Released line shows the inverse so a stale bit never passes
  assign miso_o = sel_n_i ? ~sh_r[7] : sh_r[7];
endmodule // spi_slave_model

//--- verification/spi_with_shared_port_pins_tb_top.sv
// Self-checking bench for the serial port with shared pins
`timescale 1ns/1ns
module spi_with_shared_port_pins_tb_top;
  import spi_port_pkg::*;
  logic       core_clk_i = 1'b0; // Bus clock
  logic       resetn_i   = 1'b0; // Reset, active low
  reg_req_t   req        = '0;   // Register request
  logic [7:0] rdata, pin_i, pin_o, pin_oe_o, pullup_o, rdrv_o, ext;
  logic       irq_o, miso;       // Interrupt, slave data
  logic [7:0] srx, d;            // Slave capture, read value
  logic [7:0] stx = 8'h3C;       // Byte the slave returns
  logic       arx = 1'b0, atx = 1'b0; // Async two-wire enables
  int         n_errors = 0, cmp_count = 0, n;
  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
  always #5 core_clk_i = ~core_clk_i;
  // Wire level: own drive wins, else the outside world
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & {ext[7:5], miso, ext[3:0]});
  spi_port dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_o(pullup_o), .reduced_drive_o(rdrv_o), .async_rx_en_i(arx),
    .async_tx_en_i(atx), .async_txd_i(1'b0), .irq_o(irq_o));
  spi_slave_model slave (.sck_i(pin_i[PIN_SCK]), .mosi_i(pin_i[PIN_MOSI]),
    .sel_n_i(pin_i[PIN_SEL]), .tx_i(stx), .miso_o(miso), .rx_o(srx));
  // ****************************************************************
  // Bus cycles and scenarios
  // ****************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk_i) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk_i) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i) req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_reset;
    rd(ADDR_DIR); `CHK(d, DIR_RST)
    rd(ADDR_DIVIDER); `CHK(d[2:0], 3'h0)
    `CHK(pin_oe_o, 8'h00)
  endtask
  task automatic t_master;
    wr(ADDR_DIR, 8'hE0); wr(ADDR_DIVIDER, 8'h02); wr(ADDR_CTRL1, 8'h52);
    wr(ADDR_DATA, 8'hA5);
    repeat (3) @(posedge core_clk_i);
    `CHK({pin_o[PIN_SEL], pin_oe_o[PIN_SEL]}, 2'b01)
    wr(ADDR_DATA, 8'h11);
    n = 0;
    do begin rd(ADDR_FLAGS); n++; end while (d[7] !== 1'b1 && n < 100);
    `CHK(d, 8'hC0)
    rd(ADDR_DATA); `CHK(d, 8'h3C)
    `CHK(srx, 8'hA5)
    rd(ADDR_FLAGS); `CHK(d, 8'h00)
    `CHK(pin_o[PIN_SEL], 1'b1)
  endtask
  task automatic t_lsb;
    wr(ADDR_CTRL1, 8'h53);
    stx <= 8'h03;
    wr(ADDR_DATA, 8'h01);
    n = 0;
    do begin rd(ADDR_FLAGS); n++; end while (d[7] !== 1'b1 && n < 100);
    `CHK(d, 8'h80)
    rd(ADDR_DATA); `CHK(d, 8'hC0)
    `CHK(srx, 8'h80)
  endtask
  task automatic t_fault;
    wr(ADDR_DIR, 8'h00); wr(ADDR_CTRL1, 8'hD0);
    @(posedge core_clk_i) ext[7] <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd(ADDR_FLAGS); `CHK(d, 8'h10)
    `CHK(irq_o, 1'b1)
    rd(ADDR_CTRL1); `CHK(d, 8'h80)
    @(posedge core_clk_i) ext[7] <= 1'b1;
    wr(ADDR_CTRL1, 8'h00); rd(ADDR_FLAGS); `CHK(d, 8'h00)
    `CHK(irq_o, 1'b0)
  endtask
  task automatic t_port;
    wr(ADDR_DIR, 8'h0F); wr(ADDR_PINS, 8'h0A); wr(ADDR_PULLDRV, 8'h07);
    wr(ADDR_CTRL2, 8'h08); repeat (2) @(posedge core_clk_i);
    `CHK({pin_oe_o[3:0], pin_o[3:0]}, 8'hFA)
    `CHK(rdrv_o, 8'hFF)
    `CHK(pullup_o, 8'hF0)
    rd(ADDR_PINS); `CHK({d[7:5], d[3:0]}, 7'h7A)
    @(posedge core_clk_i)
    begin
      arx <= 1'b1;
      atx <= 1'b1;
    end
    repeat (2) @(posedge core_clk_i);
    `CHK({pin_oe_o[1:0], pin_o[1]}, 3'b100)
    arx <= 1'b0;
    atx <= 1'b0;
    wr(ADDR_DIR, 8'hF0); wr(ADDR_PINS, 8'hA0); wr(ADDR_CTRL1, 8'h20);
    repeat (2) @(posedge core_clk_i);
    `CHK({pin_oe_o[7:4], pin_o[7:4]}, 8'h50)
  endtask
  task automatic t_slave;
    wr(ADDR_DIR, 8'h10); wr(ADDR_CTRL1, 8'h48);
    @(posedge core_clk_i) ext[7] <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CHK(pin_oe_o[PIN_MISO], 1'b1)
    @(posedge core_clk_i) ext[7] <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `CHK(pin_oe_o[PIN_MISO], 1'b0)
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #200000 n_errors++;
    stop_test();
  end
  initial
  begin
    ext = 8'hFF;
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_reset(); t_master(); t_lsb(); t_fault(); t_port(); t_slave();
    stop_test();
  end
endmodule // spi_with_shared_port_pins_tb_top
